// ### inc/asp_pkg.sv
// Shared constants for the converter serial host port.
// Assumes a 100 MHz system clock and an externally driven serial clock.
package asp_pkg;
    localparam int ASP_WORD_BITS = 24;
    localparam int ASP_CNT_W = 5;
    localparam logic [4:0] ASP_WORD_LAST = 5'h17;
    localparam logic [23:0] ASP_CTRL_RESET = 24'h000000;
    localparam int ASP_MODE_HI = 23;
    localparam int ASP_MODE_LO = 21;
    localparam int ASP_UNIPOLAR_BIT = 12;
    localparam logic [2:0] ASP_MODE_NORMAL = 3'h0;
    localparam int ASP_FIFO_DEPTH = 8;
endpackage

// ### rtl/asp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock domain; depth is a power of two.
`timescale 1ns/1ns
`default_nettype none
module asp_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ff;
    logic [AW:0] rd_ff;
    wire full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
    wire empty = (wr_ff == rd_ff);
    wire push = in_valid && !full;
    wire pop = out_ready && !empty;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ff[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ff[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            wr_ff <= wr_ff + (AW+1)'(push);
            rd_ff <= rd_ff + (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ### rtl/asp_port.sv
// Serial host port of a measurement converter: result hand-out,
// data-ready flag and a 24-bit control register behind the serial line.
// Assumes the host drives the serial clock (external clocking) and the
// frame syncs; conversion results come from converter logic on clk.
//
// Behaviour
// RULE_01 - Result-ready falls when a new result word is waiting to be shifted out.
// RULE_02 - Result-ready returns high once a full result word has been shifted out.
// RULE_03 - Result-ready also falls when a calibration sequence finishes.
// RULE_04 - A result read drives the data line only after read sync falls with ready low.
// RULE_05 - Write bits are sampled on rising serial clock while write sync is low.
// RULE_06 - Results are straight binary when unipolar and offset binary when bipolar.
// RULE_07 - A write with register select low goes to the control register.
// RULE_08 - A read with register select low shifts out the control register.
// RULE_09 - The control register loads only after all 24 bits arrive.
// RULE_10 - Serial clock pulses beyond the 24th in a write frame are ignored.
// RULE_11 - The host clocks out all 24 bits when reading the control register.
// RULE_12 - The host pulls write sync low to start a write.
// RULE_13 - The host lowers write sync before presenting the first bit.
// RULE_14 - The host pulls read sync low to read.
// RULE_15 - After reset the operating mode bits are zero, selecting normal mode.
// RULE_16 - The data line is released whenever no frame is active; the code releases it only at the next falling serial clock.
`timescale 1ns/1ns
`default_nettype none
module asp_port
    import asp_pkg::*;
#(
    parameter int WORD_BITS = ASP_WORD_BITS,
    parameter int FIFO_DEPTH = ASP_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic serial_clk,
    input wire logic write_frame_sync_n,
    input wire logic read_frame_sync_n,
    input wire logic register_select,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe_n,
    output logic result_ready_n,
    input wire logic [23:0] conv_result,
    input wire logic conv_result_valid,
    output logic conv_result_ready,
    input wire logic cal_done,
    output logic [2:0] operating_mode_bits,
    input wire logic cal_mode_clear
);
    // ------------------------------------------------------------
    // Result path, system clock side
    // ------------------------------------------------------------
    logic [23:0] coded_result;
    logic [23:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic [23:0] ctrl_ff;
    logic rfs_s2_ff;
    logic ack_tgl_ff;
    logic wr_tgl_ff;
    logic [23:0] wr_word_ff;
    // Unipolar: straight binary; bipolar: offset binary from two's complement
    assign coded_result = ctrl_ff[ASP_UNIPOLAR_BIT] ? conv_result
                        : {~conv_result[23], conv_result[22:0]}; // [RULE_06]

    asp_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .srst(srst),
        .in_data(coded_result),
        .in_valid(conv_result_valid),
        .in_ready(conv_result_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // Holding word shown to the link; handshake crossing below
    logic [23:0] hold_ff;
    logic hold_full_ff;
    logic cal_flag_ff;
    logic req_ff;
    logic ack_s1_ff;
    logic ack_s2_ff;
    logic ack_s3_ff;
    wire done_evt = ack_s2_ff != ack_s3_ff;
    assign fifo_pop = !hold_full_ff && fifo_valid && (ack_s2_ff == req_ff);

    always_ff @(posedge clk) begin
        if (srst) begin
            hold_ff <= '0;
            hold_full_ff <= 1'b0;
            req_ff <= 1'b0;
        end else if (fifo_pop) begin
            hold_ff <= fifo_data;
            hold_full_ff <= 1'b1; // [RULE_01]
            req_ff <= ~req_ff;
        end else if (done_evt) begin
            hold_full_ff <= 1'b0; // [RULE_02]
        end
    end

    // Calibration finish shows on ready; set wins over the read clear
    always_ff @(posedge clk) begin
        if (srst) begin
            cal_flag_ff <= 1'b0;
        end else if (cal_done) begin
            cal_flag_ff <= 1'b1; // [RULE_03]
        end else if (!rfs_s2_ff) begin
            cal_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            result_ready_n <= 1'b1;
        end else begin
            result_ready_n <= !((hold_full_ff && !done_evt) || cal_done || cal_flag_ff); // [RULE_01]
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers for the system clock side
    // ------------------------------------------------------------
    logic rfs_s1_ff;
    always_ff @(posedge clk) begin
        if (srst) begin
            rfs_s1_ff <= 1'b1;
            rfs_s2_ff <= 1'b1;
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
            ack_s3_ff <= 1'b0;
        end else begin
            rfs_s1_ff <= read_frame_sync_n;
            rfs_s2_ff <= rfs_s1_ff;
            ack_s1_ff <= ack_tgl_ff;
            ack_s2_ff <= ack_s1_ff;
            ack_s3_ff <= ack_s2_ff;
        end
    end

    // ------------------------------------------------------------
    // Control register, system clock side
    // ------------------------------------------------------------
    logic wr_s1_ff;
    logic wr_s2_ff;
    logic wr_s3_ff;
    wire ctrl_load = wr_s2_ff != wr_s3_ff;
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_s1_ff <= 1'b0;
            wr_s2_ff <= 1'b0;
            wr_s3_ff <= 1'b0;
        end else begin
            wr_s1_ff <= wr_tgl_ff;
            wr_s2_ff <= wr_s1_ff;
            wr_s3_ff <= wr_s2_ff;
        end
    end

    // Word held stable in shift domain until next full write, so safe to take
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_ff <= ASP_CTRL_RESET; // [RULE_15]
        end else if (ctrl_load) begin
            ctrl_ff <= wr_word_ff; // [RULE_09]
        end else if (cal_mode_clear) begin
            ctrl_ff[ASP_MODE_HI:ASP_MODE_LO] <= ASP_MODE_NORMAL;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            operating_mode_bits <= ASP_MODE_NORMAL;
        end else begin
            operating_mode_bits <= ctrl_ff[ASP_MODE_HI:ASP_MODE_LO];
        end
    end

    // ------------------------------------------------------------
    // Serial clock domain
    // ------------------------------------------------------------
    // The host clock runs inside frames plus one release pulse; frame syncs reset counters
    // on the first edge of each frame, so no edge outside is counted on.
    logic [ASP_CNT_W-1:0] wcnt_ff;
    logic [23:0] wshift_ff;
    logic wfs_prev_ff;
    wire write_active = !write_frame_sync_n;
    wire wr_first = write_active && wfs_prev_ff;
    wire wr_room = wr_first || (wcnt_ff <= ASP_WORD_LAST);
    wire wr_take = write_active && !register_select && wr_room; // [RULE_05] [RULE_07] [RULE_10]
    wire [ASP_CNT_W-1:0] wcnt_cur = wr_first ? '0 : wcnt_ff;
    wire [23:0] wshift_nxt = {wshift_ff[22:0], serial_data_in};

    // Plain always: link flops have no reset; counters, toggles, sync history and wr_word_ff take start values below
    always @(posedge serial_clk) begin
        wfs_prev_ff <= write_frame_sync_n;
        if (wr_take) begin
            wshift_ff <= wshift_nxt;
            wcnt_ff <= wcnt_cur + 5'h01;
            if (wcnt_cur == ASP_WORD_LAST) begin
                wr_word_ff <= wshift_nxt; // [RULE_09]
                wr_tgl_ff <= ~wr_tgl_ff;
            end
        end else if (wr_first) begin
            wcnt_ff <= 5'h00;
        end
    end

    // Read side: data changes on falling serial clock for a rising-edge sampling host
    logic [ASP_CNT_W-1:0] rcnt_ff;
    logic [23:0] rshift_ff;
    logic rfs_prev_ff;
    logic rd_result_ff;
    wire read_active = !read_frame_sync_n;
    wire rd_first = read_active && rfs_prev_ff;
    // Link clock is stopped before a frame, so nothing can be synchronised in time;
    // holding word, its flags and ctrl stay quiet while a frame runs (quasi-static)
    wire rdy_link = hold_full_ff && (req_ff != ack_tgl_ff);
    wire [23:0] rd_load = register_select ? hold_ff : ctrl_ff; // [RULE_08]

    initial begin
        wr_tgl_ff = 1'b0;
        ack_tgl_ff = 1'b0;
        wfs_prev_ff = 1'b1;
        rfs_prev_ff = 1'b1;
        wcnt_ff = 5'h00;
        rcnt_ff = 5'h00;
        wr_word_ff = ASP_CTRL_RESET;
    end

    always @(negedge serial_clk) begin
        rfs_prev_ff <= read_frame_sync_n;
        if (rd_first) begin
            rshift_ff <= {rd_load[22:0], 1'b0};
            serial_data_out <= rd_load[23];
            rcnt_ff <= 5'h01;
            rd_result_ff <= register_select && rdy_link; // [RULE_04]
        end else if (read_active && rcnt_ff <= ASP_WORD_LAST) begin
            serial_data_out <= rshift_ff[23];
            rshift_ff <= {rshift_ff[22:0], 1'b0};
            rcnt_ff <= rcnt_ff + 5'h01;
            if (rcnt_ff == ASP_WORD_LAST && rd_result_ff) begin
                ack_tgl_ff <= ~ack_tgl_ff; // [RULE_02]
            end
        end
    end

    // Line driven only from a falling edge inside a read frame with something to send, until the next falling edge
    always @(negedge serial_clk) begin
        serial_data_oe_n <= !(read_active && (!register_select
                            || (rd_first ? rdy_link : rd_result_ff))); // [RULE_04] [RULE_16]
    end
endmodule
`default_nettype wire

// ### testbench/asp_port_properties.sv
// Assertion checker for asp_port, attached by bind at the foot.
// Assumes the link clock runs only in frames plus one release pulse.
`timescale 1ns/1ns
`default_nettype none
module asp_port_properties (
    input wire logic clk,
    input wire logic srst,
    input wire logic serial_clk,
    input wire logic write_frame_sync_n,
    input wire logic read_frame_sync_n,
    input wire logic register_select,
    input wire logic serial_data_oe_n,
    input wire logic result_ready_n,
    input wire logic conv_result_valid,
    input wire logic conv_result_ready,
    input wire logic cal_done,
    input wire logic cal_mode_clear,
    input wire logic [2:0] operating_mode_bits
);
    // ----------
    // Properties
    // ----------
    logic [3:0] since_rd_ff;
    // Ready may only rise shortly after a read frame, never by itself
    always_ff @(posedge clk) begin
        if (srst || !read_frame_sync_n) begin
            since_rd_ff <= 4'h0;
        end else if (since_rd_ff != 4'hf) begin
            since_rd_ff <= since_rd_ff + 4'h1;
        end
    end
    chk_mode_reset: assert property (@(posedge clk) disable iff (srst)
        $fell(srst) |-> operating_mode_bits == 3'h0) else $error("mode bits not zero");
    chk_line_idle: assert property (@(posedge serial_clk) disable iff (srst)
        write_frame_sync_n && read_frame_sync_n |-> serial_data_oe_n)
        else $error("line driven while idle");
    chk_write_listens: assert property (@(posedge serial_clk) disable iff (srst)
        !write_frame_sync_n |-> serial_data_oe_n) else $error("line driven in write");
    chk_ctrl_read_drives: assert property (@(posedge serial_clk) disable iff (srst)
        $fell(read_frame_sync_n) && !register_select |-> !serial_data_oe_n)
        else $error("control read not driven");
    chk_data_read_held: assert property (@(posedge serial_clk) disable iff (srst)
        $fell(read_frame_sync_n) && register_select && result_ready_n |-> serial_data_oe_n)
        else $error("data driven with ready high");
    chk_cal_flags: assert property (@(posedge clk) disable iff (srst)
        cal_done && read_frame_sync_n |-> ##[1:4] !result_ready_n) else $error("cal not flagged");
    chk_result_flags: assert property (@(posedge clk) disable iff (srst)
        conv_result_valid && conv_result_ready |-> ##[1:12] !result_ready_n)
        else $error("result not flagged");
    chk_ready_release: assert property (@(posedge clk) disable iff (srst)
        $rose(result_ready_n) |-> since_rd_ff < 4'hc) else $error("ready rose without read");
    chk_mode_clear: assert property (@(posedge clk) disable iff (srst)
        cal_mode_clear |-> ##[1:3] operating_mode_bits == 3'h0) else $error("mode not cleared");
    cov_ready_fell: cover property (@(posedge clk) $fell(result_ready_n));
    cov_ctrl_read: cover property (@(posedge serial_clk) $fell(read_frame_sync_n) && !register_select);
    cov_buffer_full: cover property (@(posedge clk) conv_result_valid && !conv_result_ready);
endmodule
bind asp_port asp_port_properties i_chk (.*);
`default_nettype wire

// ### testbench/asp_host_model.sv
// Host model of the serial link: frame syncs, select, clock and data.
// Assumes the device drives on falling and samples on rising clock.
`timescale 1ns/1ns
`default_nettype none
module asp_host_model (
    output logic serial_clk,
    output logic write_frame_sync_n,
    output logic read_frame_sync_n,
    output logic register_select,
    output logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_oe_n
);
    // -----------
    // Link driver
    // -----------
    logic host_d;
    // Released line shows the host's own bit, so stale device data never reads as good
    assign serial_data_in = serial_data_oe_n ? host_d : serial_data_out;
    initial begin
        serial_clk = 1'b1;
        write_frame_sync_n = 1'b1;
        read_frame_sync_n = 1'b1;
        register_select = 1'b0;
        host_d = 1'b0;
    end
    // Clock idles high; one extra pulse after the frame lets the line go
    task automatic frame(input logic wr, input logic sel, input int nbits,
                         input logic [23:0] wd, output logic [23:0] rd);
        rd = 24'h0;
        // Off the system clock edges
        #3;
        register_select = sel;
        write_frame_sync_n = !wr;
        read_frame_sync_n = wr;
        #24;
        for (int i = 0; i < nbits; i++) begin
            serial_clk = 1'b0;
            host_d = (i < 24) ? wd[23 - i] : 1'b1;
            #24;
            serial_clk = 1'b1;
            rd = {rd[22:0], serial_data_in};
            #24;
        end
        write_frame_sync_n = 1'b1;
        read_frame_sync_n = 1'b1;
        host_d = ~host_d;
        serial_clk = 1'b0;
        #24;
        serial_clk = 1'b1;
        #24;
    endtask
endmodule
`default_nettype wire

// ### testbench/test_asp_port.sv
// Self-checking bench for asp_port: control access, results, calibration.
// Assumes asp_host_model drives the link at a 48 ns clock period.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin bad_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, s); end end
module test_asp_port;
    // ---------
    // Stimulus
    // ---------
    logic clk, srst, serial_clk, write_frame_sync_n, read_frame_sync_n;
    logic register_select, serial_data_in, serial_data_out, serial_data_oe_n;
    logic result_ready_n, conv_result_valid, conv_result_ready, cal_done, cal_mode_clear, ok;
    logic [23:0] conv_result, rd;
    logic [2:0] operating_mode_bits;
    int bad_count = 0;
    int n_checks = 0;
    int n_in = 0;
    asp_port i_dut (.*);
    asp_host_model i_host (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wait_ready(input logic lvl);
        int i;
        for (i = 0; i < 600 && result_ready_n !== lvl; i++) @(posedge clk);
        if (result_ready_n !== lvl) begin
            bad_count++;
            tally_and_finish();
        end
    endtask
    task automatic push(input logic [23:0] d);
        @(posedge clk);
        conv_result <= d;
        conv_result_valid <= 1'b1;
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            ok = (conv_result_ready === 1'b1);
        end
        conv_result_valid <= 1'b0;
    endtask
    task automatic pulse(input logic cal);
        @(posedge clk);
        cal_done <= cal;
        cal_mode_clear <= !cal;
        @(posedge clk);
        cal_done <= 1'b0;
        cal_mode_clear <= 1'b0;
    endtask
    initial begin
        srst = 1'b1;
        conv_result = 24'h0;
        conv_result_valid = 1'b0;
        cal_done = 1'b0;
        cal_mode_clear = 1'b0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        `CHK("mode", 3'h0, operating_mode_bits)
        i_host.frame(1'b0, 1'b0, 24, 24'h0, rd);
        `CHK("ctrl", 24'h0, rd)
        i_host.frame(1'b1, 1'b0, 12, 24'hffffff, rd);
        i_host.frame(1'b0, 1'b0, 24, 24'h0, rd);
        `CHK("ctrl short", 24'h0, rd)
        i_host.frame(1'b1, 1'b0, 30, 24'h201000, rd);
        `CHK("mode", 3'h1, operating_mode_bits)
        pulse(1'b0);
        i_host.frame(1'b0, 1'b0, 24, 24'h0, rd);
        `CHK("ctrl long", 24'h001000, rd)
        push(24'h123456);
        wait_ready(1'b0);
        i_host.frame(1'b0, 1'b1, 24, 24'h0, rd);
        `CHK("unipolar", 24'h123456, rd)
        wait_ready(1'b1);
        i_host.frame(1'b0, 1'b1, 24, 24'h0, rd);
        `CHK("line free", 1'b1, serial_data_oe_n)
        `CHK("no data", 24'h0, rd)
        i_host.frame(1'b1, 1'b0, 24, 24'h0, rd);
        // Offer 12 words past refusal, counting those taken; each drained word proves order and coding
        for (int k = 0; k < 12; k++) begin
            push(24'h000100 + 24'(k));
            n_in += int'(ok);
        end
        `CHK("filled", 1'b1, n_in >= 8)
        for (int k = 0; k < n_in; k++) begin
            wait_ready(1'b0);
            i_host.frame(1'b0, 1'b1, 24, 24'h0, rd);
            `CHK("bipolar", 24'h800100 + 24'(k), rd)
        end
        wait_ready(1'b1);
        pulse(1'b1);
        wait_ready(1'b0);
        i_host.frame(1'b0, 1'b0, 24, 24'h0, rd);
        `CHK("ctrl", 24'h0, rd)
        wait_ready(1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
